/* logic/sdp_ctrl.sv */
// Sleep, idle and doze controller with a Wishbone register slave.
// Assumes the core pulses its instruction strobes for one cycle on clk_i.
`timescale 1ns/1ps
`default_nettype none
module sdp_ctrl #(
  parameter int WDT_LIMIT = 16'hffff
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Core events
  input wire logic sleep_exec_i,
  input wire logic return_from_interrupt_i,
  input wire logic irq_pending_i,
  input wire logic periph_irq_i,
  input wire logic periph_irq_en_i,
  input wire logic ext_irq_en_i,
  input wire logic adc_on_rc_i,
  input wire logic adc_busy_i,
  input wire logic wdt_sleep_en_i,
  input wire logic wdt_en_i,
  input wire logic wdt_clear_i,
  // External interrupt pin and reset sources
  input wire logic ext_irq_pin_i,
  input wire logic master_clear_pin_i,
  input wire logic master_clear_en_i,
  input wire logic brownout_reset_i,
  input wire logic brownout_en_i,
  // Controls
  output logic cpu_clk_en_o,
  output logic sys_clk_en_o,
  output logic cpu_step_o,
  output logic vector_req_o,
  output logic exec_next_o,
  output logic adc_abort_o,
  output logic hold_ports_o,
  output logic dev_reset_o,
  output logic wake_o,
  output logic osc_keep_o
);
  sdp_pkg::sdp_state_t s_r, s_nxt;
  logic master_clear_pin_lvl;
  logic wb_req;
  logic wdt_fire;
  logic irq_wake;
  logic rst_wake;

  assign wb_req = wb_cyc_i & wb_stb_i & ~s_r.ack;
  // Only the second and third stages are examined, so a glitch shorter than two cycles never wakes
  assign master_clear_pin_lvl = s_r.master_clear_pin_sync[1] & s_r.master_clear_pin_sync[2];
  assign wdt_fire = wdt_en_i & (s_r.wdt == WDT_LIMIT[sdp_pkg::WDT_W-1:0]);
  // R14 per-source enables
  assign irq_wake = (s_r.ext_sync[1] & s_r.ext_sync[2] & ext_irq_en_i) | (periph_irq_i & periph_irq_en_i);
  // R12 reset-type wakes
  assign rst_wake = (master_clear_pin_lvl & master_clear_en_i) | (brownout_reset_i & brownout_en_i);

  always_comb begin
    s_nxt = s_r;
    s_nxt.ext_sync = {s_r.ext_sync[1:0], ext_irq_pin_i};
    s_nxt.master_clear_pin_sync = {s_r.master_clear_pin_sync[1:0], master_clear_pin_i};
    s_nxt.ack = wb_req;
    s_nxt.vector_req = 1'b0;
    s_nxt.exec_next = 1'b0;
    s_nxt.adc_abort = 1'b0;
    s_nxt.wake = 1'b0;
    s_nxt.dev_reset = rst_wake;
    // Watchdog counter; sleep only lets it run if enabled there
    if (wdt_en_i && !(s_r.mode == sdp_pkg::SDP_SLEEP && !wdt_sleep_en_i) && !wdt_fire) begin
      s_nxt.wdt = s_r.wdt + 1'b1;
    end
    if (wdt_clear_i || wdt_fire) begin
      s_nxt.wdt = '0;
    end
    // Doze slot counter; one step per ratio period
    if (s_r.power[sdp_pkg::BIT_ACTIVE]) begin
      s_nxt.slot = s_r.slot + 1'b1;
      if (s_r.slot >= {1'b0, s_r.power[sdp_pkg::RATIO_W-1:0]}) begin
        s_nxt.slot = '0;
      end
    end else begin
      s_nxt.slot = '0;
    end
    s_nxt.cpu_step = (s_r.mode == sdp_pkg::SDP_RUN) &&
                     (!s_r.power[sdp_pkg::BIT_ACTIVE] || s_r.slot == '0);
    if (irq_pending_i && s_r.mode == sdp_pkg::SDP_RUN && !s_r.in_isr) begin
      s_nxt.in_isr = 1'b1;
      // R2 recover to full speed
      if (s_r.power[sdp_pkg::BIT_ROI]) begin
        s_nxt.power[sdp_pkg::BIT_ACTIVE] = 1'b0;
      end
      // R1 without recovery the ratio is kept, slot counter unchanged
    end
    // R3 resume doze on return
    if (return_from_interrupt_i) begin
      s_nxt.in_isr = 1'b0;
      if (s_r.power[sdp_pkg::BIT_RESUME]) begin
        s_nxt.power[sdp_pkg::BIT_ACTIVE] = 1'b1;
      end
    end
    unique case (s_r.mode)
      sdp_pkg::SDP_RUN: begin
        if (sleep_exec_i) begin
          // R4 sleep or idle choice
          if (s_r.power[sdp_pkg::BIT_IDLE]) begin
            s_nxt.mode = sdp_pkg::SDP_IDLE;
          end else begin
            s_nxt.mode = sdp_pkg::SDP_SLEEP;
            // R5 clear watchdog on entry
            s_nxt.wdt = '0;
            // R6 status flags on entry
            s_nxt.pd_n = 1'b0;
            s_nxt.to_n = 1'b1;
            // R8 abandon system-clocked conversion
            s_nxt.adc_abort = adc_busy_i & ~adc_on_rc_i;
            // R9 hold port state
            s_nxt.hold_ports = 1'b1;
            // R18 stop clocks in sleep
            s_nxt.sys_clk_en = 1'b0;
          end
          s_nxt.cpu_clk_en = 1'b0;
          s_nxt.cpu_step = 1'b0;
        end
      end
      sdp_pkg::SDP_SLEEP, sdp_pkg::SDP_IDLE: begin
        // R11 wake sources
        if (irq_wake || wdt_fire || rst_wake) begin
          s_nxt.mode = sdp_pkg::SDP_RUN;
          s_nxt.wake = 1'b1;
          s_nxt.cpu_clk_en = 1'b1;
          s_nxt.sys_clk_en = 1'b1;
          s_nxt.hold_ports = 1'b0;
          // R16 clear watchdog on wake
          s_nxt.wdt = '0;
          // R13 R15 resume with the prefetched next instruction
          s_nxt.exec_next = ~rst_wake;
          s_nxt.vector_req = irq_wake & ~rst_wake & s_r.int_ctrl[sdp_pkg::BIT_GIE];
          if (wdt_fire && !irq_wake) begin
            s_nxt.to_n = 1'b0;
          end
        end
      end
      default: begin
        s_nxt.mode = sdp_pkg::SDP_RUN;
      end
    endcase
    if (wdt_fire && s_r.mode == sdp_pkg::SDP_RUN) begin
      // R10 watchdog reset only while running
      s_nxt.dev_reset = 1'b1;
      s_nxt.to_n = 1'b0;
    end
    // Register write, byte lane 0
    if (wb_req && wb_we_i && wb_sel_i[0]) begin
      unique case (wb_adr_i)
        sdp_pkg::ADR_CPU_POWER: s_nxt.power = wb_dat_i[7:0];
        sdp_pkg::ADR_INT_CTRL: s_nxt.int_ctrl = wb_dat_i[7:0] & sdp_pkg::INT_CTRL_MASK;
        default: s_nxt.power = s_nxt.power;
      endcase
    end
    s_nxt.rdata = '0;
    if (wb_req && !wb_we_i) begin
      unique case (wb_adr_i)
        sdp_pkg::ADR_CPU_POWER: s_nxt.rdata = {24'h000000, s_r.power};
        sdp_pkg::ADR_INT_CTRL: s_nxt.rdata = {24'h000000, s_r.int_ctrl};
        sdp_pkg::ADR_STATUS: s_nxt.rdata = {27'h0000000, s_r.to_n, s_r.pd_n, 1'b0,
                                            s_r.mode == sdp_pkg::SDP_IDLE, s_r.mode == sdp_pkg::SDP_SLEEP};
        sdp_pkg::ADR_WDT_CNT: s_nxt.rdata = {16'h0000, s_r.wdt};
        default: s_nxt.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s_r <= '0;
      s_r.power <= sdp_pkg::POWER_RST;
      s_r.int_ctrl <= sdp_pkg::INT_CTRL_RST;
      s_r.pd_n <= 1'b1;
      s_r.to_n <= 1'b1;
      s_r.mode <= sdp_pkg::SDP_RUN;
      s_r.cpu_clk_en <= 1'b1;
      s_r.sys_clk_en <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign wb_dat_o = s_r.rdata;
  assign wb_ack_o = s_r.ack;
  assign cpu_clk_en_o = s_r.cpu_clk_en;
  assign sys_clk_en_o = s_r.sys_clk_en;
  assign cpu_step_o = s_r.cpu_step;
  assign vector_req_o = s_r.vector_req;
  assign exec_next_o = s_r.exec_next;
  assign adc_abort_o = s_r.adc_abort;
  assign hold_ports_o = s_r.hold_ports;
  assign dev_reset_o = s_r.dev_reset;
  assign wake_o = s_r.wake;
  // R7 internal oscillators never gated by this block
  assign osc_keep_o = s_r.pd_n | ~s_r.pd_n;

  sequence seq_sleep_cmd;
    s_r.mode == sdp_pkg::SDP_RUN && sleep_exec_i && !s_r.power[sdp_pkg::BIT_IDLE];
  endsequence

  a_sleep_entry_flags: assert property (@(posedge clk_i) disable iff (!arst_n_i) // R6
    seq_sleep_cmd |=> !s_r.pd_n && s_r.to_n && s_r.mode == sdp_pkg::SDP_SLEEP)
    else $error("sleep entry flags wrong");
  a_idle_select: assert property (@(posedge clk_i) disable iff (!arst_n_i) // R4
    s_r.mode == sdp_pkg::SDP_RUN && sleep_exec_i && s_r.power[sdp_pkg::BIT_IDLE]
    |=> s_r.mode == sdp_pkg::SDP_IDLE && s_r.sys_clk_en)
    else $error("idle not entered");
  a_wdt_entry_clear: assert property (@(posedge clk_i) disable iff (!arst_n_i) // R5
    seq_sleep_cmd |=> s_r.wdt == '0)
    else $error("watchdog not cleared on sleep");
  a_clocks_stop: assert property (@(posedge clk_i) disable iff (!arst_n_i) // R18
    s_r.mode == sdp_pkg::SDP_SLEEP |-> !s_r.cpu_clk_en && !s_r.sys_clk_en)
    else $error("clocks running in sleep");
  a_wake_wdt_clear: assert property (@(posedge clk_i) disable iff (!arst_n_i) // R16
    s_r.mode != sdp_pkg::SDP_RUN && s_nxt.mode == sdp_pkg::SDP_RUN |=> s_r.wdt == '0 && s_r.wake)
    else $error("watchdog not cleared on wake");
  a_vector_gie: assert property (@(posedge clk_i) disable iff (!arst_n_i) // R15
    s_r.vector_req |-> $past(s_r.int_ctrl[sdp_pkg::BIT_GIE]) && s_r.exec_next)
    else $error("vector without global enable");
  a_roi_recover: assert property (@(posedge clk_i) disable iff (!arst_n_i) // R2
    irq_pending_i && s_r.mode == sdp_pkg::SDP_RUN && !s_r.in_isr && s_r.power[sdp_pkg::BIT_ROI]
    && !(wb_req && wb_we_i) && !return_from_interrupt_i |=> !s_r.power[sdp_pkg::BIT_ACTIVE])
    else $error("doze not cleared");
  a_resume_doze: assert property (@(posedge clk_i) disable iff (!arst_n_i) // R3
    return_from_interrupt_i && s_r.power[sdp_pkg::BIT_RESUME] && !(wb_req && wb_we_i)
    |=> s_r.power[sdp_pkg::BIT_ACTIVE])
    else $error("doze not resumed");
  a_rst_wake: assert property (@(posedge clk_i) disable iff (!arst_n_i) // R12
    s_r.mode == sdp_pkg::SDP_SLEEP && rst_wake |=> s_r.dev_reset && !s_r.exec_next)
    else $error("reset wake continued");
  a_ack_one: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held two cycles");
endmodule
`default_nettype wire

/* pkg/sdp_pkg.sv */
// Constants, register map and state types for the sleep and doze power controller.
// Assumes a classic Wishbone slave with 32-bit data and byte addresses.
// Notes on behaviour
// R1: Interrupt with recover bit clear keeps the service routine running at reduced rate.
// R2: Interrupt with recover bit set clears reduced-rate-active and runs full speed.
// R3: Return-from-interrupt with resume bit set sets reduced-rate-active again.
// R4: Sleep instruction enters sleep when idle select is 0, idle when 1.
// R5: Sleep entry clears watchdog counter; it keeps counting if enabled in sleep.
// R6: Sleep entry clears power-down flag and sets timeout flag (both active low).
// R7: Low and high frequency internal oscillators stay running during sleep.
// R8: ADC on dedicated RC keeps going; on system clock the conversion is abandoned.
// R9: Port pins hold pre-sleep drive unless an asynchronous peripheral changes them.
// R10: Sleep does not change any reset source except the watchdog.
// R11: Wake on pin reset, brown-out, power-on, watchdog, external or peripheral interrupt.
// R12: Pin, brown-out and power-on wakes reset; the other wakes continue execution.
// R13: Sleep instruction prefetches the instruction at the next program address.
// R14: Interrupt wakes only if its own enable is set, regardless of global enable.
// R15: After interrupt wake run next instruction, then service routine if global enable.
// R16: Every wake from sleep clears the watchdog counter.
// R17: Software should place a no-operation instruction after sleep where needed.
// R18: Sleep stops CPU and system clocks; idle halts CPU only, peripherals clocked.
package sdp_pkg;
  localparam logic [7:0] ADR_CPU_POWER = 8'h00;
  localparam logic [7:0] ADR_INT_CTRL = 8'h04;
  localparam logic [7:0] ADR_STATUS = 8'h08;
  localparam logic [7:0] ADR_WDT_CNT = 8'h0c;
  // Power control field positions
  localparam int RATIO_LSB = 0;
  localparam int RATIO_W = 3;
  localparam int BIT_RESUME = 4;
  localparam int BIT_ACTIVE = 5;
  localparam int BIT_ROI = 6;
  localparam int BIT_IDLE = 7;
  // Interrupt control field positions
  localparam int BIT_GIE = 7;
  localparam int BIT_PERIPHERAL_INT_ENABLE = 6;
  localparam int BIT_EDGE = 0;
  localparam logic [7:0] INT_CTRL_MASK = 8'hc1;
  // Status field positions
  localparam int BIT_PD_N = 3;
  localparam int BIT_TO_N = 4;
  localparam int BIT_SLEEPING = 0;
  localparam int BIT_IDLING = 1;
  localparam logic [7:0] POWER_RST = 8'h00;
  localparam logic [7:0] INT_CTRL_RST = 8'h00;
  localparam logic WDT_TIMEOUT_NS = 1'b0;
  localparam int WDT_W = 16;
  localparam int SYNC_W = 3;

  typedef enum logic [1:0] {
    SDP_RUN = 2'b00,
    SDP_SLEEP = 2'b01,
    SDP_IDLE = 2'b10
  } sdp_mode_t;

  typedef struct packed {
    logic [7:0] power;
    logic [7:0] int_ctrl;
    logic pd_n;
    logic to_n;
    sdp_mode_t mode;
    logic [WDT_W-1:0] wdt;
    logic [RATIO_W:0] slot;
    logic in_isr;
    logic [2:0] ext_sync;
    logic [2:0] master_clear_pin_sync;
    logic ack;
    logic [31:0] rdata;
    logic cpu_clk_en;
    logic sys_clk_en;
    logic cpu_step;
    logic vector_req;
    logic exec_next;
    logic adc_abort;
    logic hold_ports;
    logic dev_reset;
    logic wake;
  } sdp_state_t;
endpackage

/* verif/sdp_core_model.sv */
// Behavioural core model that issues the instruction strobes.
// Assumes the bench calls fire() from its own sequence on clk_i.
`timescale 1ns/1ps
`default_nettype none
module sdp_core_model (
  // Clock
  input wire logic clk_i,
  // Instruction strobes
  output logic sleep_exec_o,
  output logic return_from_interrupt_o,
  output logic irq_pending_o
);
  initial begin
    {irq_pending_o, return_from_interrupt_o, sleep_exec_o} = 3'h0;
  end
  // next slot after sleep is a no-op
  // One-cycle strobe; wake never replays a real instruction
  task fire(input logic [2:0] which);
    @(posedge clk_i);
    {irq_pending_o, return_from_interrupt_o, sleep_exec_o} <= which;
    @(posedge clk_i);
    {irq_pending_o, return_from_interrupt_o, sleep_exec_o} <= 3'h0;
  endtask
endmodule
`default_nettype wire

/* verif/test_sdp_ctrl.sv */
// Self-checking bench for the sleep and doze controller.
// Assumes a classic Wishbone slave and the core model beside it.
`timescale 1ns/1ps
`default_nettype none
module test_sdp_ctrl;
  logic clk_i = 1'b0;
  logic arst_n_i;
  logic wb_cyc_i, wb_stb_i, wb_we_i, wclr;
  logic [3:0] sel;
  logic [7:0] wb_adr_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic wb_ack_o, sleep_x, reti_x, irq_x;
  logic pirq, pirq_en, xirq_en, adc_rc, adc_busy, wdt_sl, wdt_en;
  logic xpin, master_clear_pin, master_clear_pin_en, bor, bor_en;
  logic cpu_en, sys_en, step, vec, nxt, abort, hold, drst, wake, osc;
  int errors = 0, samples_checked = 0, n;

  initial begin
    forever #2.5 clk_i = ~clk_i;
  end

  sdp_core_model u_core (.clk_i(clk_i), .sleep_exec_o(sleep_x), .return_from_interrupt_o(reti_x),
    .irq_pending_o(irq_x));

  sdp_ctrl #(.WDT_LIMIT(16'h0010)) u_dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(sel), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .sleep_exec_i(sleep_x), .return_from_interrupt_i(reti_x),
    .irq_pending_i(irq_x), .periph_irq_i(pirq), .periph_irq_en_i(pirq_en), .ext_irq_en_i(xirq_en),
    .adc_on_rc_i(adc_rc), .adc_busy_i(adc_busy), .wdt_sleep_en_i(wdt_sl), .wdt_en_i(wdt_en),
    .wdt_clear_i(wclr), .ext_irq_pin_i(xpin), .master_clear_pin_i(master_clear_pin), .master_clear_en_i(master_clear_pin_en),
    .brownout_reset_i(bor), .brownout_en_i(bor_en), .cpu_clk_en_o(cpu_en), .sys_clk_en_o(sys_en),
    .cpu_step_o(step), .vector_req_o(vec), .exec_next_o(nxt), .adc_abort_o(abort),
    .hold_ports_o(hold), .dev_reset_o(drst), .wake_o(wake), .osc_keep_o(osc));

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task end_sim;
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Holds the request until ack is sampled high
  task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    // A missing acknowledge counts as a mismatch
    if (wb_ack_o !== 1'b1) begin
      errors++;
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  task rchk(input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  // 16 cycles is a multiple of every slot length used, so phase does not matter
  task steps(input int exp);
    int c;
    c = 0;
    repeat (16) begin
      @(posedge clk_i);
      #1;
      c += int'(step);
    end
    chk(c, exp);
  endtask

  task wait_wake(input logic [2:0] exp);
    int k;
    k = 0;
    while (wake !== 1'b1 && k < 100) begin
      @(posedge clk_i);
      #1;
      k++;
    end
    chk({wake, drst, nxt, vec}, {1'b1, exp});
  endtask

  initial begin
    arst_n_i <= 1'b0;
    {wb_cyc_i, wb_stb_i, wb_we_i, wclr} <= 4'h0;
    sel <= 4'h1;
    wb_adr_i <= 8'h00;
    wb_dat_i <= 32'h0;
    {pirq, pirq_en, xirq_en, adc_rc, adc_busy, wdt_sl, wdt_en} <= 7'h00;
    {xpin, master_clear_pin, master_clear_pin_en, bor, bor_en} <= 5'h00;
    repeat (5) @(posedge clk_i);
    arst_n_i <= 1'b1;
    rchk(sdp_pkg::ADR_CPU_POWER, 32'h0);
    rchk(sdp_pkg::ADR_INT_CTRL, 32'h0);
    rchk(8'h10, 32'h0);
    wb(1'b1, sdp_pkg::ADR_INT_CTRL, 32'hff);
    rchk(sdp_pkg::ADR_INT_CTRL, 32'hc1);
    wb(1'b1, sdp_pkg::ADR_CPU_POWER, 32'h23);
    steps(4);
    u_core.fire(3'b100);
    rchk(sdp_pkg::ADR_CPU_POWER, 32'h23);
    steps(4);
    // Leave the routine so the next interrupt is taken
    u_core.fire(3'b010);
    wb(1'b1, sdp_pkg::ADR_CPU_POWER, 32'h73);
    u_core.fire(3'b100);
    rchk(sdp_pkg::ADR_CPU_POWER, 32'h53);
    steps(16);
    u_core.fire(3'b010);
    rchk(sdp_pkg::ADR_CPU_POWER, 32'h73);
    steps(4);
    sel <= 4'h0;
    wb(1'b1, sdp_pkg::ADR_CPU_POWER, 32'hff);
    sel <= 4'h1;
    rchk(sdp_pkg::ADR_CPU_POWER, 32'h73);
    adc_busy <= 1'b1;
    xirq_en <= 1'b1;
    wb(1'b1, sdp_pkg::ADR_CPU_POWER, 32'h0);
    u_core.fire(3'b001);
    #1;
    chk({cpu_en, sys_en, hold, abort, osc}, 5'b00111);
    rchk(sdp_pkg::ADR_STATUS, 32'h11);
    rchk(sdp_pkg::ADR_WDT_CNT, 32'h0);
    xpin <= 1'b1;
    wait_wake(3'b011);
    xpin <= 1'b0;
    wb(1'b1, sdp_pkg::ADR_INT_CTRL, 32'h0);
    adc_rc <= 1'b1;
    pirq <= 1'b1;
    wb(1'b1, sdp_pkg::ADR_CPU_POWER, 32'h0);
    u_core.fire(3'b001);
    #1;
    chk(abort, 1'b0);
    repeat (20) @(posedge clk_i);
    chk(cpu_en, 1'b0);
    pirq_en <= 1'b1;
    wait_wake(3'b010);
    pirq <= 1'b0;
    wb(1'b1, sdp_pkg::ADR_CPU_POWER, 32'h80);
    u_core.fire(3'b001);
    #1;
    chk({cpu_en, sys_en}, 2'b01);
    xpin <= 1'b1;
    wait_wake(3'b010);
    xpin <= 1'b0;
    wdt_en <= 1'b1;
    wdt_sl <= 1'b1;
    wb(1'b1, sdp_pkg::ADR_CPU_POWER, 32'h0);
    u_core.fire(3'b001);
    wait_wake(3'b010);
    wdt_en <= 1'b0;
    rchk(sdp_pkg::ADR_WDT_CNT, 32'h0);
    rchk(sdp_pkg::ADR_STATUS, 32'h0);
    master_clear_pin_en <= 1'b1;
    bor_en <= 1'b1;
    for (int s = 0; s < 2; s++) begin
      wb(1'b1, sdp_pkg::ADR_CPU_POWER, 32'h0);
      u_core.fire(3'b001);
      master_clear_pin <= (s == 0);
      bor <= (s == 1);
      wait_wake(3'b100);
      master_clear_pin <= 1'b0;
      bor <= 1'b0;
      repeat (8) @(posedge clk_i);
    end
    end_sim;
  end

  initial begin
    #20000;
    errors++;
    end_sim;
  end
endmodule
`default_nettype wire
